// ==== sic_pkg.sv ====
/*
  Package for the status indicator controller: register map, field
  positions, reset values, lamp pattern codes, timing constants and
  the packed structs that carry grouped signals.
  Assumes a 40 MHz core clock and an AXI4-Lite register bus.
*/
package sic_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ         = 40_000_000;
  localparam int TICK_MS        = 1;
  localparam int CYCLES_PER_MS  = CLK_HZ / 1000 * TICK_MS;
  localparam int RAPID_ON_MS    = 50;
  localparam int RAPID_OFF_MS   = 50;
  localparam int SLOW_ON_MS     = 200;
  localparam int SLOW_OFF_MS    = 200;
  localparam int PULSE_ON_MS    = 200;
  localparam int PULSE_OFF_MS   = 1000;
  localparam int RAPID_LEN_MS   = RAPID_ON_MS + RAPID_OFF_MS;
  localparam int SLOW_LEN_MS    = SLOW_ON_MS + SLOW_OFF_MS;
  localparam int PULSE_LEN_MS   = PULSE_ON_MS + PULSE_OFF_MS;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQST  = 8'h08;
  localparam logic [7:0] ADDR_IRQMSK = 8'h0C;
  localparam logic [7:0] ADDR_LAMPS  = 8'h10;

  // CTRL fields
  localparam int CTRL_BUS_STATE_LSB = 0;   // 2 bits
  localparam int CTRL_INPUT_ONLY    = 2;
  localparam int CTRL_HW_FAULT_FAST = 3;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // Fault / event bit positions (STATUS, IRQ status, IRQ mask)
  localparam int EV_HW        = 0;
  localparam int EV_SWITCH    = 1;
  localparam int EV_NVM       = 2;
  localparam int EV_SYNCMAN   = 3;
  localparam int EV_SYNCFREQ  = 4;
  localparam int EV_SYNCSTART = 5;
  localparam int EV_SYNCLOST  = 6;
  localparam int EV_TIMEOUT   = 7;
  localparam int NUM_EV       = 8;

  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SIC_INIT   = 2'h0,
    SIC_PREOP  = 2'h1,
    SIC_SAFEOP = 2'h2,
    SIC_OP     = 2'h3
  } sic_bus_state_t;

  typedef enum logic [2:0] {
    PAT_OFF   = 3'h0,
    PAT_ON    = 3'h1,
    PAT_RAPID = 3'h2,
    PAT_SLOW  = 3'h3,
    PAT_PULSE = 3'h4
  } sic_pat_t;

  typedef struct packed {
    logic upLink;
    logic upTraffic;
    logic downLink;
    logic downTraffic;
  } sic_port_t;

  typedef struct packed {
    logic supplyLamp;
    logic upLamp;
    logic downLamp;
    logic stateLamp;
    logic faultLamp;
  } sic_lamps_t;

endpackage

// ==== sic_status_indicator.sv ====
/*
  Status indicator controller: drives supply, two link/activity,
  network state and fault lamps from the bus state, link status and
  fault flags; AXI4-Lite register slave with sticky fault interrupts.
  Assumes all inputs synchronous to core_clk, one write and one read
  outstanding at most.
*/
// Functional notes
// - Rapid pattern: 50 ms on, 50 ms off, repeating.
// - Slow pattern: 200 ms on, 200 ms off, repeating.
// - Lone pulse pattern: 200 ms on, 1000 ms off, repeating.
// - Operational exchange: activity lamp rapid, state lamp on, fault lamp off.
// - Link up, no traffic: port lamp steady on.
// - No link: port lamp off.
// - State lamp: Init off, PreOp slow, SafeOp pulse, Op on.
// - Hardware fault: state lamp off, fault lamp on or rapid.
// - Illegal switch setting shows as a hardware fault.
// - Corrupt non-volatile data: fault lamp slow.
// - Illegal sync manager setup: setting error, fault lamp slow.
// - Input-only unit never raises a communication timeout.
// - Invalid sync frequency: state and fault lamps slow.
// - Sync start failure: state lamp slow, fault lamp pulse.
// - Sync lost: state and fault lamps pulse.
module sic_status_indicator
  import sic_pkg::*;
#(
  parameter int CYC_PER_MS = CYCLES_PER_MS
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire sic_port_t   portStat,
  input  wire logic        evHw,
  input  wire logic        evSwitch,
  input  wire logic        evNvm,
  input  wire logic        evSyncMan,
  input  wire logic        evSyncFreq,
  input  wire logic        evSyncStart,
  input  wire logic        evSyncLost,
  input  wire logic        evTimeout,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output sic_lamps_t       lamps,
  output logic             irq
);

  // ----------------------------------------------------------------
  // Millisecond timebase and pattern phases
  // ----------------------------------------------------------------
  logic [15:0] msDiv;
  logic [15:0] next_msDiv;
  logic [10:0] rapidMs, slowMs, pulseMs;
  logic [10:0] next_rapidMs, next_slowMs, next_pulseMs;
  logic        msTick;

  always_comb begin
    msTick       = (msDiv == 16'(CYC_PER_MS - 1));
    next_msDiv   = msTick ? 16'h0000 : msDiv + 16'h0001;
    next_rapidMs = rapidMs;
    next_slowMs  = slowMs;
    next_pulseMs = pulseMs;
    if (msTick) begin
      next_rapidMs = (rapidMs == 11'(RAPID_LEN_MS - 1)) ? 11'h000 : rapidMs + 11'h001;
      next_slowMs  = (slowMs == 11'(SLOW_LEN_MS - 1)) ? 11'h000 : slowMs + 11'h001;
      next_pulseMs = (pulseMs == 11'(PULSE_LEN_MS - 1)) ? 11'h000 : pulseMs + 11'h001;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      msDiv   <= 16'h0000;
      rapidMs <= 11'h000;
      slowMs  <= 11'h000;
      pulseMs <= 11'h000;
    end else begin
      msDiv   <= next_msDiv;
      rapidMs <= next_rapidMs;
      slowMs  <= next_slowMs;
      pulseMs <= next_pulseMs;
    end
  end

  logic rapidOn, slowOn, pulseOn;
  assign rapidOn = (rapidMs < 11'(RAPID_ON_MS));
  assign slowOn  = (slowMs < 11'(SLOW_ON_MS));
  assign pulseOn = (pulseMs < 11'(PULSE_ON_MS));

  function automatic logic patLevel(input sic_pat_t p, input logic r, input logic s,
                                    input logic u);
    case (p)
      PAT_ON:    patLevel = 1'b1;
      PAT_RAPID: patLevel = r;
      PAT_SLOW:  patLevel = s;
      PAT_PULSE: patLevel = u;
      default:   patLevel = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [31:0]       ctrl, next_ctrl;
  logic [NUM_EV-1:0] irqSt, next_irqSt;
  logic [NUM_EV-1:0] irqMsk, next_irqMsk;
  logic [NUM_EV-1:0] evIn, evLive;
  logic              inputOnly;
  sic_bus_state_t    busState;

  assign busState  = sic_bus_state_t'(ctrl[CTRL_BUS_STATE_LSB +: 2]);
  assign inputOnly = ctrl[CTRL_INPUT_ONLY];
  assign evIn = {evTimeout & ~inputOnly, evSyncLost, evSyncStart, evSyncFreq,
                 evSyncMan, evNvm, evSwitch, evHw};
  assign evLive = evIn;

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic        awHeld, wHeld, next_awHeld, next_wHeld;
  logic [7:0]  awAddr, next_awAddr;
  logic [31:0] wData, next_wData;
  logic [3:0]  wStrb, next_wStrb;
  logic        next_bvalid, next_rvalid;
  logic [1:0]  next_bresp, next_rresp;
  logic [31:0] next_rdata, wMask;
  logic        doWrite;
  sic_lamps_t  next_lamps;

  always_comb begin
    next_awHeld = awHeld;
    next_wHeld  = wHeld;
    next_awAddr = awAddr;
    next_wData  = wData;
    next_wStrb  = wStrb;
    if (s_axi_awvalid && s_axi_awready) begin
      next_awHeld = 1'b1;
      next_awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_wHeld = 1'b1;
      next_wData = s_axi_wdata;
      next_wStrb = s_axi_wstrb;
    end
    doWrite = awHeld && wHeld && !s_axi_bvalid;
    for (int i = 0; i < 4; i++) begin
      wMask[i*8 +: 8] = {8{wStrb[i]}};
    end
    next_ctrl   = ctrl;
    next_irqMsk = irqMsk;
    next_irqSt  = irqSt;
    next_bvalid = s_axi_bvalid && !s_axi_bready;
    next_bresp  = s_axi_bresp;
    if (doWrite) begin
      next_awHeld = 1'b0;
      next_wHeld  = 1'b0;
      next_bvalid = 1'b1;
      next_bresp  = AXI_OKAY;
      case (awAddr)
        ADDR_CTRL:   next_ctrl   = (ctrl & ~wMask) | (wData & wMask);
        ADDR_IRQMSK: next_irqMsk = (irqMsk & ~wMask[NUM_EV-1:0]) | (wData[NUM_EV-1:0] &
                                   wMask[NUM_EV-1:0]);
        ADDR_IRQST:  next_irqSt  = irqSt & ~(wData[NUM_EV-1:0] & wMask[NUM_EV-1:0]);
        ADDR_STATUS, ADDR_LAMPS: next_bresp = AXI_OKAY;
        default:     next_bresp  = AXI_SLVERR;
      endcase
    end
    next_irqSt  = next_irqSt | evIn;  // Set wins over clear
    next_rvalid = s_axi_rvalid && !s_axi_rready;
    next_rdata  = s_axi_rdata;
    next_rresp  = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = AXI_OKAY;
      case (s_axi_araddr)
        ADDR_CTRL:   next_rdata = ctrl;
        ADDR_STATUS: next_rdata = {24'h000000, evLive};
        ADDR_IRQST:  next_rdata = {24'h000000, irqSt};
        ADDR_IRQMSK: next_rdata = {24'h000000, irqMsk};
        ADDR_LAMPS:  next_rdata = {27'h0, lamps};
        default: begin
          next_rdata = 32'h0000_0000;
          next_rresp = AXI_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      awHeld        <= 1'b0;
      wHeld         <= 1'b0;
      awAddr        <= 8'h00;
      wData         <= 32'h0000_0000;
      wStrb         <= 4'h0;
      ctrl          <= CTRL_RESET;
      irqSt         <= '0;
      irqMsk        <= '0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= AXI_OKAY;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= AXI_OKAY;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
      irq           <= 1'b0;
      lamps         <= '0;
    end else begin
      awHeld        <= next_awHeld;
      wHeld         <= next_wHeld;
      awAddr        <= next_awAddr;
      wData         <= next_wData;
      wStrb         <= next_wStrb;
      ctrl          <= next_ctrl;
      irqSt         <= next_irqSt;
      irqMsk        <= next_irqMsk;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
      s_axi_awready <= !next_awHeld && !next_bvalid && !s_axi_awready;
      s_axi_wready  <= !next_wHeld && !next_bvalid && !s_axi_wready;
      s_axi_arready <= !next_rvalid && !s_axi_arready;
      irq           <= |(next_irqSt & next_irqMsk);
      lamps         <= next_lamps;
    end
  end

  // ----------------------------------------------------------------
  // Lamp selection
  // ----------------------------------------------------------------
  sic_pat_t statePat, faultPat, upPat, downPat;

  always_comb begin
    case (busState)
      SIC_PREOP:  statePat = PAT_SLOW;
      SIC_SAFEOP: statePat = PAT_PULSE;
      SIC_OP:     statePat = PAT_ON;
      default:    statePat = PAT_OFF;
    endcase
    faultPat = PAT_OFF;
    // Severity order: least severe first, later entries override
    if (evLive[EV_TIMEOUT]) begin
      faultPat = PAT_PULSE;
    end
    if (evLive[EV_NVM] || evLive[EV_SYNCMAN]) begin
      faultPat = PAT_SLOW;
    end
    if (evLive[EV_SYNCLOST]) begin
      statePat = PAT_PULSE;
      faultPat = PAT_PULSE;
    end
    if (evLive[EV_SYNCSTART]) begin
      statePat = PAT_SLOW;
      faultPat = PAT_PULSE;
    end
    if (evLive[EV_SYNCFREQ]) begin
      statePat = PAT_SLOW;
      faultPat = PAT_SLOW;
    end
    if (evLive[EV_HW] || evLive[EV_SWITCH]) begin
      statePat = PAT_OFF;
      faultPat = ctrl[CTRL_HW_FAULT_FAST] ? PAT_RAPID : PAT_ON;
    end
    upPat   = !portStat.upLink ? PAT_OFF :
              (portStat.upTraffic ? PAT_RAPID : PAT_ON);
    downPat = !portStat.downLink ? PAT_OFF :
              (portStat.downTraffic ? PAT_RAPID : PAT_ON);
    next_lamps.supplyLamp = 1'b1;
    next_lamps.upLamp     = patLevel(upPat, rapidOn, slowOn, pulseOn);
    next_lamps.downLamp   = patLevel(downPat, rapidOn, slowOn, pulseOn);
    next_lamps.stateLamp  = patLevel(statePat, rapidOn, slowOn, pulseOn);
    next_lamps.faultLamp  = patLevel(faultPat, rapidOn, slowOn, pulseOn);
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_no_link_off: assert property (@(posedge core_clk) disable iff (!rst_n)
    !portStat.upLink |=> !lamps.upLamp) else $error("up lamp lit without link");
  a_link_idle_on: assert property (@(posedge core_clk) disable iff (!rst_n)
    portStat.upLink && !portStat.upTraffic |=> lamps.upLamp)
    else $error("idle link lamp not on");
  a_hw_state_off: assert property (@(posedge core_clk) disable iff (!rst_n)
    (evHw || evSwitch) |=> !lamps.stateLamp) else $error("state lamp on in hw fault");
  a_switch_fault: assert property (@(posedge core_clk) disable iff (!rst_n)
    evSwitch && !ctrl[CTRL_HW_FAULT_FAST] |=> lamps.faultLamp)
    else $error("switch fault lamp not on");
  a_timeout_masked: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(inputOnly) && !$past(irqSt[EV_TIMEOUT]) |-> !irqSt[EV_TIMEOUT])
    else $error("timeout raised on input-only unit");
  a_rapid_phase: assert property (@(posedge core_clk) disable iff (!rst_n)
    msTick && rapidMs == 11'(RAPID_ON_MS - 1) |=> !rapidOn) else $error("rapid on too long");
  a_pulse_phase: assert property (@(posedge core_clk) disable iff (!rst_n)
    msTick && pulseMs == 11'(PULSE_LEN_MS - 1) |=> pulseOn && pulseMs == 11'h000)
    else $error("pulse cycle length wrong");
  a_slow_phase: assert property (@(posedge core_clk) disable iff (!rst_n)
    msTick && slowMs == 11'(SLOW_ON_MS - 1) |=> !slowOn ##1 !slowOn)
    else $error("slow on too long");
  a_op_state_on: assert property (@(posedge core_clk) disable iff (!rst_n)
    busState == SIC_OP && !(|evLive[EV_SYNCLOST:EV_HW]) |=> lamps.stateLamp)
    else $error("op state lamp not on");

endmodule

// ==== sic_lamp_panel.sv ====
/*
  Front-panel observer for the status indicator controller: watches
  the five lamps and records the length of the last completed lit and
  dark interval of each, plus a count of rising edges.
  Assumes lamps change only at rising core_clk edges.
*/
module sic_lamp_panel
  import sic_pkg::*;
(
  input  wire logic       core_clk,
  input  wire sic_lamps_t lamps,
  output int              onLen[5],
  output int              offLen[5],
  output int              rises[5]
);
  // --------------------------------------------------------------
  // Interval measurement
  // --------------------------------------------------------------
  logic [4:0] prev = 5'h00;
  int         run[5];

  initial begin
    for (int i = 0; i < 5; i++) begin
      run[i] = 0;
      onLen[i] = 0;
      offLen[i] = 0;
      rises[i] = 0;
    end
  end

  always @(posedge core_clk) begin
    for (int i = 0; i < 5; i++) begin
      if (lamps[i] !== prev[i]) begin
        if (prev[i]) onLen[i] <= run[i];
        else offLen[i] <= run[i];
        if (lamps[i] === 1'b1) rises[i] <= rises[i] + 1;
        run[i] <= 1;
      end else begin
        run[i] <= run[i] + 1;
      end
    end
    prev <= lamps;
  end
endmodule

// ==== tb_status_indicator_controller.sv ====
/*
  Self-checking bench for the status indicator controller: AXI4-Lite
  master tasks, lamp pattern checks through the panel observer.
  Assumes CYC_PER_MS of 2 and the register map of the package.
*/
module tb_status_indicator_controller
  import sic_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int CPM = 2;
  logic        core_clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [7:0]  ev, awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, rs;
  sic_port_t   portStat;
  sic_lamps_t  lamps;
  int          onLen[5], offLen[5], rises[5];
  int          fail_count, n_checks;

  sic_status_indicator #(.CYC_PER_MS(CPM)) i_dut (
    .core_clk(core_clk), .rst_n(rst_n), .portStat(portStat),
    .evHw(ev[EV_HW]), .evSwitch(ev[EV_SWITCH]), .evNvm(ev[EV_NVM]),
    .evSyncMan(ev[EV_SYNCMAN]), .evSyncFreq(ev[EV_SYNCFREQ]),
    .evSyncStart(ev[EV_SYNCSTART]), .evSyncLost(ev[EV_SYNCLOST]),
    .evTimeout(ev[EV_TIMEOUT]), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .lamps(lamps), .irq(irq));

  sic_lamp_panel i_panel (.core_clk(core_clk), .lamps(lamps), .onLen(onLen),
    .offLen(offLen), .rises(rises));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
      fail_count++;
    end
  endtask

  task automatic hang(input string nm);
    $display("MISMATCH %s expected response seen timeout", nm);
    fail_count++;
    report_and_stop();
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    int  n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && n < 100);
    if (!bvalid) hang("write");
    chk("bresp", AXI_OKAY, bresp);
    bready <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic axi_read(input logic [7:0] a);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (!arready && n < 100);
    if (!arready) hang("read");
    arvalid <= 1'b0;
    rready <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (!rvalid && n < 200);
    if (!rvalid) hang("read");
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  // Steady level over 300 cycles, or full lit and dark interval lengths
  task automatic chk_lamp(input int idx, input sic_pat_t p);
    logic seen;
    int   r, n, onMs, offMs;
    if (p == PAT_OFF || p == PAT_ON) begin
      seen = (p == PAT_ON);
      repeat (2) @(posedge core_clk);
      repeat (300) begin
        @(posedge core_clk);
        if (lamps[idx] !== (p == PAT_ON)) seen = lamps[idx];
      end
      chk($sformatf("lamp %0d level", idx), (p == PAT_ON), seen);
      return;
    end
    onMs = (p == PAT_RAPID) ? RAPID_ON_MS : (p == PAT_SLOW) ? SLOW_ON_MS : PULSE_ON_MS;
    offMs = (p == PAT_RAPID) ? RAPID_OFF_MS : (p == PAT_SLOW) ? SLOW_OFF_MS : PULSE_OFF_MS;
    r = rises[idx];
    n = 0;
    while (rises[idx] < r + 3 && n < 4 * CPM * (onMs + offMs)) begin
      @(posedge core_clk);
      n++;
    end
    if (rises[idx] < r + 3) hang("lamp pattern");
    chk($sformatf("lamp %0d on", idx), onMs * CPM, onLen[idx]);
    chk($sformatf("lamp %0d off", idx), offMs * CPM, offLen[idx]);
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_reset();
    chk("supply lamp", 1, lamps.supplyLamp);
    axi_read(ADDR_CTRL);
    chk("ctrl reset", CTRL_RESET, rd);
    axi_read(8'h20);
    chk("unmapped rresp", AXI_SLVERR, rs);
    axi_read(ADDR_LAMPS);
    chk("lamp register", 32'h0000_0010, rd);
    chk_lamp(1, PAT_OFF);
    chk_lamp(3, PAT_OFF);
    $display("test reset done");
  endtask

  task automatic t_ports();
    portStat <= '{upLink: 1'b1, upTraffic: 1'b0, downLink: 1'b0, downTraffic: 1'b0};
    chk_lamp(3, PAT_ON);
    chk_lamp(2, PAT_OFF);
    axi_write(ADDR_CTRL, 32'h0000_0003);
    portStat.upTraffic <= 1'b1;
    chk_lamp(3, PAT_RAPID);
    chk_lamp(1, PAT_ON);
    chk_lamp(0, PAT_OFF);
    portStat.downLink <= 1'b1;
    portStat.downTraffic <= 1'b1;
    chk_lamp(2, PAT_RAPID);
    $display("test ports done");
  endtask

  task automatic t_states();
    sic_pat_t exp[4] = '{PAT_OFF, PAT_SLOW, PAT_PULSE, PAT_ON};
    for (int s = 0; s < 4; s++) begin
      axi_write(ADDR_CTRL, 32'(s));
      chk_lamp(1, exp[s]);
    end
    $display("test states done");
  endtask

  task automatic t_fault(input logic [7:0] e, input logic [31:0] c, input bit chkSt,
                         input sic_pat_t stP, input sic_pat_t fP);
    axi_write(ADDR_CTRL, c);
    ev <= e;
    repeat (3) @(posedge core_clk);
    if (chkSt) chk_lamp(1, stP);
    chk_lamp(0, fP);
    ev <= 8'h00;
    repeat (3) @(posedge core_clk);
    $display("test fault %0h done", e);
  endtask

  task automatic t_irq();
    axi_write(ADDR_IRQST, 32'h0000_00FF);
    axi_write(ADDR_IRQMSK, 32'h0000_0000);
    ev <= 8'h04;
    repeat (3) @(posedge core_clk);
    axi_read(ADDR_IRQST);
    chk("irq status nvm", 32'h0000_0004, rd);
    axi_read(ADDR_STATUS);
    chk("live status nvm", 32'h0000_0004, rd);
    chk("irq masked", 0, irq);
    axi_write(ADDR_IRQMSK, 32'h0000_00FF);
    ev <= 8'h00;
    repeat (3) @(posedge core_clk);
    chk("irq sticky", 1, irq);
    axi_write(ADDR_IRQST, 32'h0000_0004);
    repeat (3) @(posedge core_clk);
    chk("irq cleared", 0, irq);
    axi_write(ADDR_CTRL, 32'h0000_0004);
    ev <= 8'h80;
    repeat (3) @(posedge core_clk);
    axi_read(ADDR_IRQST);
    chk("input only timeout", 32'h0000_0000, rd);
    chk("input only irq", 0, irq);
    axi_write(ADDR_CTRL, 32'h0000_0000);
    repeat (3) @(posedge core_clk);
    axi_read(ADDR_IRQST);
    chk("timeout status", 32'h0000_0080, rd);
    axi_write(ADDR_IRQST, 32'h0000_0080);
    axi_read(ADDR_IRQST);
    chk("set wins clear", 32'h0000_0080, rd);
    ev <= 8'h00;
    repeat (2) @(posedge core_clk);
    axi_write(ADDR_IRQST, 32'h0000_00FF);
    $display("test irq done");
  endtask

  task automatic t_recover();
    ev <= 8'h04;
    repeat (3) @(posedge core_clk);
    chk("nvm irq before restart", 1, irq);
    ev <= 8'h00;
    rst_n <= 1'b0;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    axi_read(ADDR_IRQST);
    chk("irq status after restart", 32'h0000_0000, rd);
    chk("irq after restart", 0, irq);
    chk_lamp(0, PAT_OFF);
    $display("test recover done");
  endtask

  initial begin
    fail_count = 0;
    n_checks = 0;
    rst_n = 1'b0;
    ev = 8'h00;
    portStat = '0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    t_reset();
    t_ports();
    t_states();
    t_fault(8'h01, 32'h3, 1, PAT_OFF, PAT_ON);
    t_fault(8'h01, 32'hB, 1, PAT_OFF, PAT_RAPID);
    t_fault(8'h02, 32'h3, 1, PAT_OFF, PAT_ON);
    t_fault(8'h04, 32'h3, 0, PAT_OFF, PAT_SLOW);
    t_fault(8'h08, 32'h3, 0, PAT_OFF, PAT_SLOW);
    t_fault(8'h10, 32'h3, 1, PAT_SLOW, PAT_SLOW);
    t_fault(8'h20, 32'h3, 1, PAT_SLOW, PAT_PULSE);
    t_fault(8'h40, 32'h3, 1, PAT_PULSE, PAT_PULSE);
    t_fault(8'h05, 32'h3, 1, PAT_OFF, PAT_ON);
    t_irq();
    t_recover();
    report_and_stop();
  end
endmodule
